// ===== logic/pkw_pkg.sv
// Package with register map, field layout and carrier types for the port/keypad block
package pkw_pkg;
  localparam logic [7:0] ADDR_P2_AUX_MODE  = 8'ha4;
  localparam logic [7:0] ADDR_P2_MODE_2ND  = 8'ha8;
  localparam logic [7:0] ADDR_KP_MASK      = 8'hac;
  localparam logic [7:0] ADDR_AUX_CTRL     = 8'hb0;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hb4;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'hb8;

  localparam logic [7:0] RST_P2_AUX_MODE   = 8'h00;
  localparam logic [7:0] RST_P2_MODE_2ND   = 8'h00;
  localparam logic [7:0] RST_KP_MASK       = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL      = 8'h00;
  localparam logic [2:0] RST_IRQ           = 3'h0;
  localparam logic [7:0] RST_PORT0_LEVEL   = 8'hff;

  localparam int BIT_P2_HYS     = 7;
  localparam int BIT_P1_HYS     = 6;
  localparam int BIT_P0_HYS     = 5;
  localparam int BIT_CLK_OUT_EN = 4;
  localparam int BIT_T1_TOGGLE  = 3;
  localparam int BIT_T0_TOGGLE  = 2;
  localparam int BIT_P2_PIN1    = 1;
  localparam int BIT_P2_PIN0    = 0;
  localparam int BIT_KP_FLAG    = 7;
  localparam int BIT_KP_IRQ_EN  = 0;

  localparam int EV_KEYPAD      = 0;
  localparam int EV_T0_OVF      = 1;
  localparam int EV_T1_OVF      = 2;

  // Clock output is the CPU clock divided by six
  localparam int       CLK_OUT_DIV  = 6;
  localparam logic [1:0] CLK_OUT_HALF = 2'(CLK_OUT_DIV / 2 - 1);

  typedef enum logic [1:0] {
    PKW_QUASI_BIDIR = 2'h0,
    PKW_PUSH_PULL   = 2'h1,
    PKW_INPUT_ONLY  = 2'h2,
    PKW_OPEN_DRAIN  = 2'h3
  } pkw_out_mode_t;

  typedef struct packed {
    logic          port2_hysteresis_en;
    logic          port1_hysteresis_en;
    logic          port0_hysteresis_en;
    pkw_out_mode_t port2_pin1_mode;
    pkw_out_mode_t port2_pin0_mode;
  } pkw_port_cfg_t;
endpackage

// ===== logic/pkw_port_aux.sv
// Port auxiliary configuration, toggle outputs and keypad wake logic with AHB-Lite registers
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps

// What this block does
// - Aux mode register at A4h, resets to 00h, written only as whole byte.
// - Bits 7, 6, 5 enable Schmitt inputs on ports 2, 1, 0.
// - Bit 4 enables clock output on port 2 pin 0 only with RC oscillator.
// - Bit 3 toggles the timer 1 pin on each timer 1 overflow.
// - Bit 2 toggles port 1 pin 2 on each timer 0 overflow.
// - Bits 1, 0 with second mode register pick port 2 pin 1, 0 modes.
// - Pair decodes 00 quasi, 01 push-pull, 10 input only, 11 open drain.
// - Keypad mask bit n admits port 0 pin n as keypad source.
// - Flag sets while any enabled port 0 pin is low and keypad active.
// - Flag requests interrupt only when keypad interrupt is enabled.
// - Flag stays set until software writes it to zero.
// - Keypad flag sits in bit 7 of aux control register.
// - Keypad mask has no effect unless keypad interrupt is enabled.
// - Keypad interrupt wakes the CPU from Idle and Power Down.
module pkw_port_aux (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [7:0]             port0_pin_in,
  input  wire logic                   timer0_ovf,
  input  wire logic                   timer1_ovf,
  input  wire logic                   rc_osc_sel,
  input  wire logic                   cpu_idle,
  input  wire logic                   cpu_power_down,
  output pkw_pkg::pkw_port_cfg_t      port_cfg,
  output logic                        clock_out_en,
  output logic                        osc_out_pin,
  output logic                        timer1_toggle_pin,
  output logic                        port1_pin2,
  output logic                        keypad_irq_req,
  output logic                        wake_req,
  output logic                        irq
);

  logic [7:0] port2_aux_mode_config_reg;
  logic [7:0] port2_mode_second_reg;
  logic [7:0] keypad_pin_enable_mask_reg;
  logic       keypad_irq_flag_reg;
  logic       keypad_irq_en_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;

  logic       dph_wr_reg;
  logic [7:0] dph_addr_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] port0_level_reg;
  logic [1:0] clk_div_reg;
  logic       kp_flag_prev_reg;

  logic       addr_phase;
  logic       wr_aux_mode;
  logic       wr_mode_2nd;
  logic       wr_kp_mask;
  logic       wr_aux_ctrl;
  logic       wr_status;
  logic       wr_mask;
  logic       keypad_hit;
  logic       kp_flag_next;
  logic [2:0] events;
  logic [2:0] irq_status_next;
  logic [31:0] rdata_next;
  logic       clk_out_active;

  // Bus address phase capture
  assign addr_phase = hsel & htrans[1] & hready;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= 8'h00;
    end else begin
      dph_wr_reg   <= addr_phase & hwrite;
      dph_addr_reg <= haddr[7:0];
    end
  end

  // Whole-byte register writes only
  assign wr_aux_mode = dph_wr_reg && dph_addr_reg == pkw_pkg::ADDR_P2_AUX_MODE;
  assign wr_mode_2nd = dph_wr_reg && dph_addr_reg == pkw_pkg::ADDR_P2_MODE_2ND;
  assign wr_kp_mask  = dph_wr_reg && dph_addr_reg == pkw_pkg::ADDR_KP_MASK;
  assign wr_aux_ctrl = dph_wr_reg && dph_addr_reg == pkw_pkg::ADDR_AUX_CTRL;
  assign wr_status   = dph_wr_reg && dph_addr_reg == pkw_pkg::ADDR_IRQ_STATUS;
  assign wr_mask     = dph_wr_reg && dph_addr_reg == pkw_pkg::ADDR_IRQ_MASK;

  // Aux mode register, whole byte only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port2_aux_mode_config_reg <= pkw_pkg::RST_P2_AUX_MODE;
    end else if (wr_aux_mode) begin
      port2_aux_mode_config_reg <= hwdata[7:0];
    end
  end

  // Second port 2 mode register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port2_mode_second_reg <= pkw_pkg::RST_P2_MODE_2ND;
    end else if (wr_mode_2nd) begin
      port2_mode_second_reg <= hwdata[7:0];
    end
  end

  // Keypad pin enable mask
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keypad_pin_enable_mask_reg <= pkw_pkg::RST_KP_MASK;
    end else if (wr_kp_mask) begin
      keypad_pin_enable_mask_reg <= hwdata[7:0];
    end
  end

  // Keypad interrupt enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keypad_irq_en_reg <= pkw_pkg::RST_AUX_CTRL[pkw_pkg::BIT_KP_IRQ_EN];
    end else if (wr_aux_ctrl) begin
      keypad_irq_en_reg <= hwdata[pkw_pkg::BIT_KP_IRQ_EN];
    end
  end

  // Interrupt mask register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask_reg <= pkw_pkg::RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_reg <= hwdata[2:0];
    end
  end

  // Port 0 pin synchroniser, three flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_reg <= pkw_pkg::RST_PORT0_LEVEL;
      sync2_reg <= pkw_pkg::RST_PORT0_LEVEL;
      sync3_reg <= pkw_pkg::RST_PORT0_LEVEL;
    end else begin
      sync1_reg <= port0_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Level taken once second and third flops agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port0_level_reg <= pkw_pkg::RST_PORT0_LEVEL;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          port0_level_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Keypad detection, gated by the keypad interrupt enable
  assign keypad_hit = keypad_irq_en_reg & |(keypad_pin_enable_mask_reg & ~port0_level_reg);

  // Flag is sticky; a hit in the clearing cycle wins
  always_comb begin
    kp_flag_next = keypad_irq_flag_reg;
    if (wr_aux_ctrl && !hwdata[pkw_pkg::BIT_KP_FLAG]) begin
      kp_flag_next = 1'b0;
    end
    if (keypad_hit) begin
      kp_flag_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keypad_irq_flag_reg <= pkw_pkg::RST_AUX_CTRL[pkw_pkg::BIT_KP_FLAG];
    end else begin
      keypad_irq_flag_reg <= kp_flag_next;
    end
  end

  // Flag history for the status edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      kp_flag_prev_reg <= 1'b0;
    end else begin
      kp_flag_prev_reg <= keypad_irq_flag_reg;
    end
  end

  // Sticky event status, write one to clear, set wins
  assign events[pkw_pkg::EV_KEYPAD] = keypad_irq_flag_reg & ~kp_flag_prev_reg;
  assign events[pkw_pkg::EV_T0_OVF] = timer0_ovf;
  assign events[pkw_pkg::EV_T1_OVF] = timer1_ovf;

  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_status) begin
      irq_status_next = irq_status_reg & ~hwdata[2:0];
    end
    irq_status_next = irq_status_next | events;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status_reg <= pkw_pkg::RST_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Level interrupt while an unmasked status bit is set
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Keypad interrupt request and wake
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keypad_irq_req <= 1'b0;
    end else begin
      keypad_irq_req <= kp_flag_next & keypad_irq_en_reg;
    end
  end

  // Wake from Idle or Power Down
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= kp_flag_next & keypad_irq_en_reg & (cpu_idle | cpu_power_down);
    end
  end

  // Pin configuration outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_cfg <= '0;
    end else begin
      port_cfg.port2_hysteresis_en <= port2_aux_mode_config_reg[pkw_pkg::BIT_P2_HYS];
      port_cfg.port1_hysteresis_en <= port2_aux_mode_config_reg[pkw_pkg::BIT_P1_HYS];
      port_cfg.port0_hysteresis_en <= port2_aux_mode_config_reg[pkw_pkg::BIT_P0_HYS];
      port_cfg.port2_pin1_mode <= pkw_pkg::pkw_out_mode_t'({
        port2_aux_mode_config_reg[pkw_pkg::BIT_P2_PIN1],
        port2_mode_second_reg[pkw_pkg::BIT_P2_PIN1]});
      port_cfg.port2_pin0_mode <= pkw_pkg::pkw_out_mode_t'({
        port2_aux_mode_config_reg[pkw_pkg::BIT_P2_PIN0],
        port2_mode_second_reg[pkw_pkg::BIT_P2_PIN0]});
    end
  end

  // Clock output on port 2 pin 0, divide by six
  assign clk_out_active = port2_aux_mode_config_reg[pkw_pkg::BIT_CLK_OUT_EN] & rc_osc_sel;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clock_out_en <= 1'b0;
    end else begin
      clock_out_en <= clk_out_active;
    end
  end

  // Divider and square wave, held low while off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clk_div_reg <= 2'h0;
      osc_out_pin <= 1'b0;
    end else begin
      if (!clk_out_active) begin
        clk_div_reg <= 2'h0;
        osc_out_pin <= 1'b0;
      end else if (clk_div_reg == pkw_pkg::CLK_OUT_HALF) begin
        clk_div_reg <= 2'h0;
        osc_out_pin <= ~osc_out_pin;
      end else begin
        clk_div_reg <= clk_div_reg + 2'h1;
      end
    end
  end

  // Timer overflow toggle outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer1_toggle_pin <= 1'b0;
    end else if (timer1_ovf && port2_aux_mode_config_reg[pkw_pkg::BIT_T1_TOGGLE]) begin
      timer1_toggle_pin <= ~timer1_toggle_pin;
    end
  end

  // Port 1 pin 2 toggles on timer 0 overflow
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port1_pin2 <= 1'b0;
    end else if (timer0_ovf && port2_aux_mode_config_reg[pkw_pkg::BIT_T0_TOGGLE]) begin
      port1_pin2 <= ~port1_pin2;
    end
  end

  // Read data prepared in the address phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (haddr[7:0])
      pkw_pkg::ADDR_P2_AUX_MODE: rdata_next[7:0] = port2_aux_mode_config_reg;
      pkw_pkg::ADDR_P2_MODE_2ND: rdata_next[7:0] = port2_mode_second_reg;
      pkw_pkg::ADDR_KP_MASK:     rdata_next[7:0] = keypad_pin_enable_mask_reg;
      pkw_pkg::ADDR_AUX_CTRL: begin
        rdata_next[pkw_pkg::BIT_KP_FLAG]   = keypad_irq_flag_reg;
        rdata_next[pkw_pkg::BIT_KP_IRQ_EN] = keypad_irq_en_reg;
      end
      pkw_pkg::ADDR_IRQ_STATUS:  rdata_next[2:0] = irq_status_reg;
      pkw_pkg::ADDR_IRQ_MASK:    rdata_next[2:0] = irq_mask_reg;
      default:                   rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

endmodule

// ===== tb/pkw_keypad_model.sv
// Keypad model: switches to ground on port 0 pins
`timescale 1ns/100ps
module pkw_keypad_model (
  input  wire logic [7:0] key_down,
  output logic      [7:0] port0_pin_in
);
  // Released keys read high through pull-ups
  assign port0_pin_in = ~key_down;
endmodule

// ===== tb/pkw_port_aux_checker.sv
// Assertion checker for the port aux and keypad block
`timescale 1ns/100ps
module pkw_port_aux_checker (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  timer0_ovf,
  input wire logic                  timer1_ovf,
  input wire logic                  rc_osc_sel,
  input wire logic                  cpu_idle,
  input wire logic                  cpu_power_down,
  input wire pkw_pkg::pkw_port_cfg_t port_cfg,
  input wire logic                  clock_out_en,
  input wire logic                  osc_out_pin,
  input wire logic                  timer1_toggle_pin,
  input wire logic                  port1_pin2,
  input wire logic                  keypad_irq_req,
  input wire logic                  wake_req
);
  logic wr1, wr2, wr3;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Write address phase history
  always_ff @(posedge ref_clk) begin
    wr1 <= hsel && htrans[1] && hwrite;
    wr2 <= wr1;
    wr3 <= wr2;
  end
  cfg_hold_a: assert property (!(wr1 || wr2 || wr3) |-> $stable(port_cfg))
    else $error("port config moved without a write");
  clk_gate_a: assert property (clock_out_en |-> $past(rc_osc_sel))
    else $error("clock out enabled without rc oscillator");
  osc_idle_a: assert property (osc_out_pin |-> clock_out_en || $past(clock_out_en))
    else $error("clock pin active while disabled");
  osc_high_a: assert property ($rose(osc_out_pin) ##0 clock_out_en[*3] |-> osc_out_pin)
    else $error("clock out high phase too short");
  osc_low_a: assert property ($fell(osc_out_pin) ##0 clock_out_en[*3] |-> !osc_out_pin)
    else $error("clock out low phase too short");
  osc_period_a: assert property ($rose(osc_out_pin) |-> ##3 !osc_out_pin)
    else $error("clock out high phase too long");
  t1_hold_a: assert property (!$past(timer1_ovf) && !$past(timer1_ovf, 2)
    |-> $stable(timer1_toggle_pin))
    else $error("timer 1 pin moved without overflow");
  t0_hold_a: assert property (!$past(timer0_ovf) && !$past(timer0_ovf, 2)
    |-> $stable(port1_pin2))
    else $error("timer 0 pin moved without overflow");
  flag_keep_a: assert property (keypad_irq_req && !wr1 |=> keypad_irq_req)
    else $error("keypad request dropped without a write");
  wake_link_a: assert property (wake_req
    == (keypad_irq_req && $past(cpu_idle || cpu_power_down)))
    else $error("wake request mismatch");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule

bind pkw_port_aux pkw_port_aux_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
  .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf), .rc_osc_sel(rc_osc_sel),
  .cpu_idle(cpu_idle), .cpu_power_down(cpu_power_down), .port_cfg(port_cfg),
  .clock_out_en(clock_out_en), .osc_out_pin(osc_out_pin), .port1_pin2(port1_pin2),
  .timer1_toggle_pin(timer1_toggle_pin), .keypad_irq_req(keypad_irq_req), .wake_req(wake_req));

// ===== tb/pkw_port_aux_tb_top.sv
// Self-checking bench for the port aux and keypad block
`timescale 1ns/100ps
module pkw_port_aux_tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, t0 = 1'b0, t1 = 1'b0;
  logic rc = 1'b0, idle = 1'b0, pd = 1'b0, e0 = 1'b0, e1 = 1'b0;
  logic hready, hresp, ck_en, ck_pin, t1_pin, t0_pin, kreq, wake, irq;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, hi;
  logic [7:0]  keys = 8'h0, pins, a, b;
  pkw_pkg::pkw_port_cfg_t cfg;
  int err_total = 0, comparisons = 0, n, p;
  always #50 ref_clk = ~ref_clk;
  pkw_keypad_model kp (.key_down(keys), .port0_pin_in(pins));
  pkw_port_aux uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .port0_pin_in(pins),
    .timer0_ovf(t0), .timer1_ovf(t1), .rc_osc_sel(rc), .cpu_idle(idle),
    .cpu_power_down(pd), .port_cfg(cfg), .clock_out_en(ck_en), .osc_out_pin(ck_pin),
    .timer1_toggle_pin(t1_pin), .port1_pin2(t0_pin), .keypad_irq_req(kreq),
    .wake_req(wake), .irq(irq));
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdy;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_total++;
        $display("[ERR] hready expected 1 seen %b", hready);
        give_verdict;
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] cfg_exp(input logic [7:0] x, input logic [7:0] y);
    return {25'h0, x[7:5], x[1], y[1], x[0], y[0]};
  endfunction
  initial begin
    n = $urandom(45);
    cyc(5);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, 8'ha4 + 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hff : 8'($urandom) & 8'hef;
      b = 8'($urandom);
      {a[1], b[1]} = 2'(i);
      xfer(1'b1, pkw_pkg::ADDR_P2_AUX_MODE, {24'h0, a});
      xfer(1'b1, pkw_pkg::ADDR_P2_MODE_2ND, {24'h0, b});
      xfer(1'b0, pkw_pkg::ADDR_P2_AUX_MODE, 32'h0);
      chk("aux mode", {24'h0, a}, rd);
      chk("port cfg", cfg_exp(a, b), {25'h0, cfg});
    end
    xfer(1'b1, pkw_pkg::ADDR_P2_AUX_MODE, 32'h10);
    cyc(3);
    chk("clock off", 32'h0, {31'h0, ck_en});
    rc <= 1'b1;
    cyc(6);
    hi = 32'h0;
    b = 8'h0;
    a[0] = ck_pin;
    repeat (12) begin
      @(posedge ref_clk);
      hi += {31'h0, ck_pin};
      b += {7'h0, ck_pin ^ a[0]};
      a[0] = ck_pin;
    end
    chk("clock duty", 32'h6, hi);
    chk("clock edges", 32'h4, {24'h0, b});
    xfer(1'b1, pkw_pkg::ADDR_P2_AUX_MODE, 32'h0c);
    for (int i = 0; i < 10; i++) begin
      if (i == 6) xfer(1'b1, pkw_pkg::ADDR_P2_AUX_MODE, 32'h0);
      a = (i == 0) ? 8'h3 : 8'($urandom);
      t0 <= a[0];
      t1 <= a[1];
      @(posedge ref_clk);
      t0 <= 1'b0;
      t1 <= 1'b0;
      cyc(2);
      e0 ^= a[0] & (i < 6);
      e1 ^= a[1] & (i < 6);
      chk("t0 pin", {31'h0, e0}, {31'h0, t0_pin});
      chk("t1 pin", {31'h0, e1}, {31'h0, t1_pin});
    end
    xfer(1'b0, pkw_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("status", 32'h6, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, pkw_pkg::ADDR_IRQ_MASK, 32'h2);
    cyc(2);
    chk("irq on", 32'h1, {31'h0, irq});
    xfer(1'b1, pkw_pkg::ADDR_IRQ_STATUS, 32'h6);
    cyc(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    p = $urandom % 8;
    xfer(1'b1, pkw_pkg::ADDR_KP_MASK, 32'h1 << p);
    xfer(1'b1, pkw_pkg::ADDR_AUX_CTRL, 32'h1);
    keys <= 8'h1 << p;
    cyc(12);
    chk("key request", 32'h1, {31'h0, kreq});
    chk("no wake", 32'h0, {31'h0, wake});
    for (int i = 0; i < 2; i++) begin
      idle <= (i == 0);
      pd <= (i == 1);
      cyc(2);
      chk("wake", 32'h1, {31'h0, wake});
    end
    idle <= 1'b0;
    pd <= 1'b0;
    xfer(1'b0, pkw_pkg::ADDR_AUX_CTRL, 32'h0);
    chk("aux ctrl", 32'h81, rd);
    keys <= 8'h0;
    cyc(12);
    chk("flag held", 32'h1, {31'h0, kreq});
    xfer(1'b1, pkw_pkg::ADDR_AUX_CTRL, 32'h1);
    cyc(2);
    chk("flag clear", 32'h0, {31'h0, kreq});
    keys <= 8'h1 << ((p + 1) % 8);
    cyc(12);
    chk("other pin", 32'h0, {31'h0, kreq});
    xfer(1'b1, pkw_pkg::ADDR_AUX_CTRL, 32'h80);
    keys <= 8'h1 << p;
    cyc(12);
    xfer(1'b0, pkw_pkg::ADDR_AUX_CTRL, 32'h0);
    chk("inactive", 32'h0, rd);
    xfer(1'b1, 8'hbc, 32'hff);
    xfer(1'b0, 8'hbc, 32'h0);
    chk("unmapped", 32'h0, rd);
    give_verdict;
  end
endmodule
